// [rtl/irq_ctrl_regs.svh]
// Register indices, field positions, reset values and vector constants
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// Register indices: byte address is four times the index
`define IE_MAIN_IDX   8'ha8
`define IE_EXT_IDX    8'hbd
`define PRIO_LO_IDX   8'hb8
`define PRIO_HI_IDX   8'hba
`define EPRIO_LO_IDX  8'hbc
`define EPRIO_HI_IDX  8'hbb
`define EXT_CTRL_IDX  8'hc0
`define EXT_FLAG_IDX  8'hc1
`define SVC_STAT_IDX  8'hc2

// Writable bit masks, reserved bits stay zero
`define IE_MAIN_MASK  8'hbf
`define IE_EXT_MASK   8'h07
`define PRIO_LO_MASK  8'h3f
`define EPRIO_MASK    8'h07

// Reset values
`define IE_MAIN_RST   8'h00
`define IE_EXT_RST    8'h00
`define PRIO_RST      8'h00
`define EXT_CTRL_RST  8'h00

// Field positions
`define GATE_BIT      7
`define TMR2_EN_BIT   5
`define UART_EN_BIT   4
`define TMR1_EN_BIT   3
`define EXT1_EN_BIT   2
`define TMR0_EN_BIT   1
`define EXT0_EN_BIT   0
`define BOD_EN_BIT    2
`define WAKE_EN_BIT   1
`define SPI_EN_BIT    0

// Sources and vectors
`define NUM_SRC       11
`define VEC_STRIDE    16'h0008
`define VEC_OFS       16'h0003

// Bus answers
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// [rtl/irq_ctrl_pkg.sv]
// Types and shared functions of the interrupt controller
`include "irq_ctrl_regs.svh"

package irq_ctrl_pkg;

   typedef logic [1:0] prio_type;
   typedef logic [3:0] vec_num_type;

   // Take handshake towards the core, one bit changes per step except SETTLE back to IDLE
   typedef enum logic [1:0] {
      TK_IDLE   = 2'b00,
      TK_OFFER  = 2'b01,
      TK_SETTLE = 2'b11
   } take_state_type;

   // Vector number n sits at 8*n+3
   function automatic logic [15:0] vec_addr(input vec_num_type n);
      vec_addr = 16'(n) * `VEC_STRIDE + `VEC_OFS;
   endfunction

   // Highest level currently in service
   function automatic prio_type top_level(input logic [3:0] svc);
      top_level = 2'd0;
      for (int i = 0; i < 4; i++) begin
         if (svc[i]) begin
            top_level = prio_type'(i);
         end
      end
   endfunction

endpackage

// [rtl/irq_prio_arb.sv]
// Fixed-priority arbiter over all request sources
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module irq_prio_arb (
   input  wire logic [10:0]             req_i,   // Enabled requests
   input  wire logic [10:0]             lo_i,    // Priority low bits
   input  wire logic [10:0]             hi_i,    // Priority high bits
   output logic                         valid_o, // Any request
   output irq_ctrl_pkg::vec_num_type    num_o,   // Winning vector
   output irq_ctrl_pkg::prio_type       lvl_o    // Winning level
);

   // four-level arbitration
   // Scan from the top so equal levels fall to the lowest number
   // lowest number wins ties
   always_comb begin
      valid_o = 1'b0;
      num_o   = 4'h0;
      lvl_o   = 2'd0;
      for (int n = `NUM_SRC - 1; n >= 0; n--) begin
         if (req_i[n] && (!valid_o || {hi_i[n], lo_i[n]} >= lvl_o)) begin
            valid_o = 1'b1;
            num_o   = 4'(n);
            lvl_o   = {hi_i[n], lo_i[n]};
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/irq_enable_vector_ctrl.sv]
// Interrupt enable, priority, nesting and vector logic with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.svh"

// Behaviour
// - Eleven sources, four priority levels
// - Each source: flag, enable, priority, vector
// - Taken request vectors core, marks service
// - Only strictly higher level pre-empts service
// - Return instruction ends the active service
// - Vector number n sits at 8n+3
// - Timer 2 events share vector five
// - Wake-up timer uses vector nine
// - Main enable bit 7 gates everything
// - Main bit 5 enables timer 2
// - Main bit 4 enables serial port
// - Main bit 3 enables timer 1
// - Main bit 2 enables pin 1
// - Main bit 1 enables timer 0
// - Main bit 0 enables pin 0
// - Extended bit 2 enables brown-out
// - Extended bit 1 enables wake-up timer
// - Extended bit 0 enables SPI flags
// - Extended enable resets zero, bits 7:3 reserved
// - Low and high bits form level
// - Pin flags: falling edge or inverted level
module irq_enable_vector_ctrl (
   input  wire logic        ref_clk_i,          // Core clock
   input  wire logic        sys_rst_i,          // Sync reset, high
   input  wire logic        ce_i,               // Clock enable
   input  wire logic [9:0]  s_axi_awaddr_i,     // Write address
   input  wire logic        s_axi_awvalid_i,    // Write address valid
   output logic             s_axi_awready_o,    // Write address ready
   input  wire logic [31:0] s_axi_wdata_i,      // Write data
   input  wire logic [3:0]  s_axi_wstrb_i,      // Write strobes
   input  wire logic        s_axi_wvalid_i,     // Write data valid
   output logic             s_axi_wready_o,     // Write data ready
   output logic [1:0]       s_axi_bresp_o,      // Write response
   output logic             s_axi_bvalid_o,     // Write response valid
   input  wire logic        s_axi_bready_i,     // Write response ready
   input  wire logic [9:0]  s_axi_araddr_i,     // Read address
   input  wire logic        s_axi_arvalid_i,    // Read address valid
   output logic             s_axi_arready_o,    // Read address ready
   output logic [31:0]      s_axi_rdata_o,      // Read data
   output logic [1:0]       s_axi_rresp_o,      // Read response
   output logic             s_axi_rvalid_o,     // Read data valid
   input  wire logic        s_axi_rready_i,     // Read data ready
   input  wire logic [3:0]  ext_irq_pin_n_i,    // External pins 0..3
   input  wire logic        tmr0_ovf_flag_i,    // Timer 0 overflow
   input  wire logic        tmr1_ovf_flag_i,    // Timer 1 overflow
   input  wire logic        tmr2_ovf_flag_i,    // Timer 2 overflow
   input  wire logic        tmr2_ext_flag_i,    // Timer 2 event
   input  wire logic        uart_tx_done_i,     // Serial tx done
   input  wire logic        uart_rx_done_i,     // Serial rx done
   input  wire logic        spi_done_flag_i,    // SPI complete
   input  wire logic        spi_overrun_flag_i, // SPI overrun
   input  wire logic        spi_mode_fault_i,   // SPI mode fault
   input  wire logic        wake_tmr_flag_i,    // Wake-up timer
   input  wire logic        brownout_flag_i,    // Brown-out
   output logic             irq_req_o,          // Vector offered
   input  wire logic        irq_ack_i,          // Core takes vector
   output logic [15:0]      irq_vec_addr_o,     // Vector address
   output logic [3:0]       irq_vec_num_o,      // Vector number
   input  wire logic        irq_return_instr_i, // Return executed
   output logic             irq_active_o,       // In service state
   output logic [3:0]       irq_in_service_o    // Levels in service
);

   // ************************************************************
   // Registers and state
   // ************************************************************
   logic [7:0]                  ie_main_ff;
   logic [7:0]                  ie_ext_ff;
   logic [7:0]                  prio_lo_ff;
   logic [7:0]                  prio_hi_ff;
   logic [7:0]                  eprio_lo_ff;
   logic [7:0]                  eprio_hi_ff;
   logic [7:0]                  ext_ctrl_ff;
   logic [3:0]                  ext_flag_ff;
   logic [3:0]                  pin_s1_ff;
   logic [3:0]                  pin_s2_ff;
   logic [3:0]                  pin_prev_ff;
   logic [3:0]                  in_svc_ff;
   irq_ctrl_pkg::take_state_type tk_state_ff;
   irq_ctrl_pkg::take_state_type nxt_tk_state;
   irq_ctrl_pkg::vec_num_type   vec_num_ff;
   irq_ctrl_pkg::prio_type      lvl_ff;
   logic [15:0]                 vec_addr_ff;
   logic                        aw_ok_ff;
   logic                        w_ok_ff;
   logic [9:0]                  awaddr_ff;
   logic [31:0]                 wdata_ff;
   logic                        wstrb0_ff;
   logic                        bvalid_ff;
   logic [1:0]                  bresp_ff;
   logic                        rvalid_ff;
   logic [1:0]                  rresp_ff;
   logic [31:0]                 rdata_ff;
   logic                        do_wr;
   logic                        wr_en;
   logic [3:0]                  sw_clr;
   logic [3:0]                  ack_clr;
   logic [3:0]                  pin_fall;
   logic [10:0]                 src_flag;
   logic [10:0]                 src_en;
   logic [10:0]                 req_vec;
   logic [10:0]                 lvl_lo;
   logic [10:0]                 lvl_hi;
   logic                        win_valid;
   irq_ctrl_pkg::vec_num_type   win_num;
   irq_ctrl_pkg::prio_type      win_lvl;
   irq_ctrl_pkg::prio_type      cur_lvl;
   logic                        eligible;
   logic                        take;

   // Known register index
   function automatic logic reg_known(input logic [7:0] idx);
      case (idx)
         `IE_MAIN_IDX, `IE_EXT_IDX, `PRIO_LO_IDX, `PRIO_HI_IDX,
         `EPRIO_LO_IDX, `EPRIO_HI_IDX, `EXT_CTRL_IDX, `EXT_FLAG_IDX,
         `SVC_STAT_IDX: reg_known = 1'b1;
         default: reg_known = 1'b0;
      endcase
   endfunction

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   // Address and data are held until both are present
   assign s_axi_awready_o = !aw_ok_ff && !bvalid_ff;
   assign s_axi_wready_o  = !w_ok_ff && !bvalid_ff;
   assign do_wr           = aw_ok_ff && w_ok_ff && !bvalid_ff;
   assign wr_en           = do_wr && wstrb0_ff;
   assign s_axi_bvalid_o  = bvalid_ff;
   assign s_axi_bresp_o   = bresp_ff;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         aw_ok_ff  <= 1'b0;
         w_ok_ff   <= 1'b0;
         awaddr_ff <= 10'h000;
         wdata_ff  <= 32'h0000_0000;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= `RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_ok_ff   <= 1'b1;
            wdata_ff  <= s_axi_wdata_i;
            wstrb0_ff <= s_axi_wstrb_i[0];
         end
         if (do_wr) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= reg_known(awaddr_ff[9:2]) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready_i) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   assign s_axi_arready_o = !rvalid_ff;
   assign s_axi_rvalid_o  = rvalid_ff;
   assign s_axi_rresp_o   = rresp_ff;
   assign s_axi_rdata_o   = rdata_ff;

   // Read data is captured at the address edge; unmapped reads zero
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= `RESP_OKAY;
         rdata_ff  <= 32'h0000_0000;
      end else if (ce_i) begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= reg_known(s_axi_araddr_i[9:2]) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr_i[9:2])
               `IE_MAIN_IDX:  rdata_ff <= {24'h000000, ie_main_ff};
               `IE_EXT_IDX:   rdata_ff <= {24'h000000, ie_ext_ff};
               `PRIO_LO_IDX:  rdata_ff <= {24'h000000, prio_lo_ff};
               `PRIO_HI_IDX:  rdata_ff <= {24'h000000, prio_hi_ff};
               `EPRIO_LO_IDX: rdata_ff <= {24'h000000, eprio_lo_ff};
               `EPRIO_HI_IDX: rdata_ff <= {24'h000000, eprio_hi_ff};
               `EXT_CTRL_IDX: rdata_ff <= {24'h000000, ext_ctrl_ff};
               `EXT_FLAG_IDX: rdata_ff <= {28'h0000000, ext_flag_ff};
               `SVC_STAT_IDX: rdata_ff <= {24'h000000, in_svc_ff, vec_num_ff};
               default:       rdata_ff <= 32'h0000_0000;
            endcase
         end else if (rvalid_ff && s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Enable and priority registers
   // ************************************************************
   // extended enable clears at reset
   // Only lane 0 carries data; reserved bits are masked off
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ie_main_ff  <= `IE_MAIN_RST;
         ie_ext_ff   <= `IE_EXT_RST;
         prio_lo_ff  <= `PRIO_RST;
         prio_hi_ff  <= `PRIO_RST;
         eprio_lo_ff <= `PRIO_RST;
         eprio_hi_ff <= `PRIO_RST;
         ext_ctrl_ff <= `EXT_CTRL_RST;
      end else if (ce_i && wr_en) begin
         case (awaddr_ff[9:2])
            `IE_MAIN_IDX:  ie_main_ff  <= wdata_ff[7:0] & `IE_MAIN_MASK;
            `IE_EXT_IDX:   ie_ext_ff   <= wdata_ff[7:0] & `IE_EXT_MASK;
            `PRIO_LO_IDX:  prio_lo_ff  <= wdata_ff[7:0] & `PRIO_LO_MASK;
            `PRIO_HI_IDX:  prio_hi_ff  <= wdata_ff[7:0];
            `EPRIO_LO_IDX: eprio_lo_ff <= wdata_ff[7:0] & `EPRIO_MASK;
            `EPRIO_HI_IDX: eprio_hi_ff <= wdata_ff[7:0] & `EPRIO_MASK;
            `EXT_CTRL_IDX: ext_ctrl_ff <= wdata_ff[7:0];
            default:       ;
         endcase
      end
   end

   // ************************************************************
   // External pin flags
   // ************************************************************
   // Pins idle high, so the synchroniser resets high to avoid a false edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_s1_ff   <= 4'hf;
         pin_s2_ff   <= 4'hf;
         pin_prev_ff <= 4'hf;
      end else if (ce_i) begin
         pin_s1_ff   <= ext_irq_pin_n_i;
         pin_s2_ff   <= pin_s1_ff;
         pin_prev_ff <= pin_s2_ff;
      end
   end

   assign pin_fall = pin_prev_ff & ~pin_s2_ff;
   assign sw_clr   = (wr_en && awaddr_ff[9:2] == `EXT_FLAG_IDX) ? wdata_ff[3:0] : 4'h0;
   assign ack_clr  = {take && vec_num_ff == 4'h7, take && vec_num_ff == 4'h6,
                      take && vec_num_ff == 4'h2, take && vec_num_ff == 4'h0};

   // edge sets flag, level follows inverted pin
   // A fresh edge wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ext_flag_ff <= 4'h0;
      end else if (ce_i) begin
         for (int i = 0; i < 4; i++) begin
            if (ext_ctrl_ff[i]) begin
               ext_flag_ff[i] <= pin_fall[i] | (ext_flag_ff[i] & ~(sw_clr[i] | ack_clr[i]));
            end else begin
               ext_flag_ff[i] <= ~pin_s2_ff[i];
            end
         end
      end
   end

   // ************************************************************
   // Request gating and arbitration
   // ************************************************************
   // one flag and enable per source
   // timer 2 events merge on vector 5
   // serial events merge on vector 4
   // three SPI flags merge on vector 8
   assign src_flag = {brownout_flag_i, wake_tmr_flag_i,
                      spi_done_flag_i | spi_overrun_flag_i | spi_mode_fault_i,
                      ext_flag_ff[3], ext_flag_ff[2],
                      tmr2_ovf_flag_i | tmr2_ext_flag_i,
                      uart_tx_done_i | uart_rx_done_i,
                      tmr1_ovf_flag_i, ext_flag_ff[1], tmr0_ovf_flag_i, ext_flag_ff[0]};

   // wake-up timer enable bit
   // Pins 2 and 3 take their enables from the pin control register
   assign src_en = {ie_ext_ff[`BOD_EN_BIT], ie_ext_ff[`WAKE_EN_BIT], ie_ext_ff[`SPI_EN_BIT],
                    ext_ctrl_ff[7], ext_ctrl_ff[6],
                    ie_main_ff[`TMR2_EN_BIT], ie_main_ff[`UART_EN_BIT],
                    ie_main_ff[`TMR1_EN_BIT], ie_main_ff[`EXT1_EN_BIT],
                    ie_main_ff[`TMR0_EN_BIT], ie_main_ff[`EXT0_EN_BIT]};

   assign req_vec = ie_main_ff[`GATE_BIT] ? (src_flag & src_en) : 11'h000;

   // level is high bit over low bit
   assign lvl_lo = {eprio_lo_ff[2:0], ext_ctrl_ff[5:4], prio_lo_ff[5:0]};
   assign lvl_hi = {eprio_hi_ff[2:0], prio_hi_ff};

   irq_prio_arb irq_prio_arb_i (
      .req_i   (req_vec),
      .lo_i    (lvl_lo),
      .hi_i    (lvl_hi),
      .valid_o (win_valid),
      .num_o   (win_num),
      .lvl_o   (win_lvl)
   );

   assign cur_lvl  = irq_ctrl_pkg::top_level(in_svc_ff);
   assign eligible = win_valid && (in_svc_ff == 4'h0 || win_lvl > cur_lvl);

   // ************************************************************
   // Take handshake and nesting
   // ************************************************************
   assign take      = irq_req_o && irq_ack_i;
   assign irq_req_o = tk_state_ff == irq_ctrl_pkg::TK_OFFER;

   // Settle one cycle after a take so the new level is seen
   always_comb begin
      nxt_tk_state = tk_state_ff;
      unique case (tk_state_ff)
         irq_ctrl_pkg::TK_IDLE:   if (eligible) nxt_tk_state = irq_ctrl_pkg::TK_OFFER;
         irq_ctrl_pkg::TK_OFFER: begin
            if (irq_ack_i) begin
               nxt_tk_state = irq_ctrl_pkg::TK_SETTLE;
            end else if (!eligible) begin
               nxt_tk_state = irq_ctrl_pkg::TK_IDLE;
            end
         end
         irq_ctrl_pkg::TK_SETTLE: nxt_tk_state = irq_ctrl_pkg::TK_IDLE;
         default:                 nxt_tk_state = irq_ctrl_pkg::TK_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tk_state_ff <= irq_ctrl_pkg::TK_IDLE;
      end else if (ce_i) begin
         tk_state_ff <= nxt_tk_state;
      end
   end

   // vector address is 8n+3
   // Vector follows the winner but freezes on the take edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         vec_num_ff  <= 4'h0;
         lvl_ff      <= 2'd0;
         vec_addr_ff <= 16'h0000;
      end else if (ce_i && eligible && !take) begin
         vec_num_ff  <= win_num;
         lvl_ff      <= win_lvl;
         vec_addr_ff <= irq_ctrl_pkg::vec_addr(win_num);
      end
   end

   // take marks the level in service
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         in_svc_ff <= 4'h0;
      end else if (ce_i) begin
         in_svc_ff <= (irq_return_instr_i ? in_svc_ff & ~(4'h1 << cur_lvl) : in_svc_ff)
                      | (take ? 4'h1 << lvl_ff : 4'h0);
      end
   end

   assign irq_vec_addr_o   = vec_addr_ff;
   assign irq_vec_num_o    = vec_num_ff;
   assign irq_active_o     = in_svc_ff != 4'h0;
   assign irq_in_service_o = in_svc_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   gate_blocks_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !ie_main_ff[`GATE_BIT] && $past(!ie_main_ff[`GATE_BIT]) && $past(ce_i) |-> !irq_req_o)
      else $error("request offered while gate closed");

   vec_addr_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o |-> irq_vec_addr_o == 16'(irq_vec_num_o) * 16'h0008 + 16'h0003)
      else $error("vector address does not match number");

   preempt_lvl_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_req_o && irq_active_o |-> lvl_ff > cur_lvl)
      else $error("offer does not outrank service level");

   take_marks_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      take && ce_i |=> in_svc_ff[$past(lvl_ff)] && !irq_req_o)
      else $error("take did not mark service");

   return_ends_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_return_instr_i && ce_i && !take && irq_active_o
      |=> $countones(in_svc_ff) == $countones($past(in_svc_ff)) - 1)
      else $error("return did not end one service level");

   edge_sets_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ce_i && ext_ctrl_ff[0] && pin_fall[0] |=> ext_flag_ff[0])
      else $error("falling edge lost");

   ext_reset_a: assert property (@(posedge ref_clk_i)
      $past(sys_rst_i) |-> ie_ext_ff == 8'h00 && ie_ext_ff[7:3] == 5'h00)
      else $error("extended enable not cleared by reset");

   tmr2_share_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ie_main_ff[7] && ie_main_ff[5] && (tmr2_ovf_flag_i || tmr2_ext_flag_i) |-> req_vec[5])
      else $error("timer 2 event not requested");

   spi_en_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_vec[8] |-> ie_ext_ff[0] && ie_main_ff[7])
      else $error("SPI request without enable");

   take_cov: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) take);
   nest_cov: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $countones(in_svc_ff) == 2);
   ret_cov: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      irq_return_instr_i && irq_active_o);

endmodule
`default_nettype wire

// [testbench/core_model.sv]
// Processor core model: takes offered vectors and jumps to them
`timescale 1ns/10ps
`default_nettype none
module core_model (
   input  wire logic        clk_i,     // Core clock
   input  wire logic        rst_i,     // Sync reset, high
   input  wire logic        req_i,     // Vector offered
   input  wire logic [15:0] addr_i,    // Vector address
   input  wire logic        take_en_i, // Accept offers
   output logic             ack_o,     // Take pulse
   output logic [15:0]      pc_o       // Program counter
);
   // jump to vector
   // Ack one cycle after the offer, so a slow core is what the block sees
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         pc_o <= 16'h0000;
      end else begin
         ack_o <= req_i && take_en_i && !ack_o;
         if (req_i && ack_o) pc_o <= addr_i;
      end
   end
endmodule
`default_nettype wire

// [testbench/test_irq_enable_vector_ctrl.sv]
// Self-checking bench for the interrupt enable and vector controller
`timescale 1ns/10ps
`default_nettype none
module test_irq_enable_vector_ctrl;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, take = 0, ret = 0;
   logic awready, wready, bvalid, arready, rvalid, irq_req, ack, active, ta, tw, tr;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, q;
   logic [1:0] bresp, rresp;
   logic [10:0] fl = 0;
   logic [3:0] insvc, num;
   logic [3:0] pin_n = 4'hf;
   logic [15:0] irq_addr, pc;
   int failures = 0, cmp_count = 0;
   always #5 clk = ~clk;
   irq_enable_vector_ctrl irq_enable_vector_ctrl_i (.ref_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .ext_irq_pin_n_i(pin_n), .tmr0_ovf_flag_i(fl[0]),
      .tmr1_ovf_flag_i(fl[1]), .tmr2_ovf_flag_i(fl[2]), .tmr2_ext_flag_i(fl[3]),
      .uart_tx_done_i(fl[4]), .uart_rx_done_i(fl[5]), .spi_done_flag_i(fl[6]),
      .spi_overrun_flag_i(fl[7]), .spi_mode_fault_i(fl[8]), .wake_tmr_flag_i(fl[9]),
      .brownout_flag_i(fl[10]), .irq_req_o(irq_req), .irq_ack_i(ack), .irq_vec_addr_o(irq_addr),
      .irq_vec_num_o(num), .irq_return_instr_i(ret), .irq_active_o(active),
      .irq_in_service_o(insvc));
   core_model core_model_i (.clk_i(clk), .rst_i(rst), .req_i(irq_req), .addr_i(irq_addr),
      .take_en_i(take), .ack_o(ack), .pc_o(pc));
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One AXI4-Lite transfer; readies are sampled mid-cycle so the edge decision is race free
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] r);
      int n;
      logic tb;
      n = 0;
      tb = 0;
      awaddr <= a;
      araddr <= a;
      wdata <= {24'h0, d};
      {awv, wv, bready, arv, rready} <= {w, w, w, !w, !w};
      while (!tb && n < 50) begin
         @(negedge clk);
         {ta, tw, tr, tb} = {awready && awv, wready && wv, arready && arv, w ? bvalid : rvalid};
         r = w ? {bresp, 30'h0} : {rresp, rdata[29:0]};
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         if (tr) arv <= 0;
         n++;
      end
      if (!tb) begin
         failures++;
         tally_and_finish;
      end
   endtask
   // Waits for an offer of vector n, or watches that none comes
   task automatic offer(input logic [3:0] n, input logic p);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         if (!p) chk(irq_req, 0);
         i++;
      end while (i < 20 && !(p && irq_req === 1'b1));
      if (p) chk({irq_req, num, irq_addr}, {1'b1, n, 16'(n) * 16'h8 + 16'h3});
      if (p && irq_req !== 1'b1) tally_and_finish;
      @(posedge clk);
   endtask
   // Waits for the take cycle itself, since the old program counter may already match
   task automatic take_it(input logic [15:0] e);
      int i;
      i = 0;
      take <= 1;
      do begin
         @(negedge clk);
         i++;
      end while (i < 10 && !(ack === 1'b1 && irq_req === 1'b1));
      chk({ack, irq_req}, 2'b11);
      @(posedge clk);
      take <= 0;
      @(negedge clk);
      chk({active, pc}, {1'b1, e});
      @(posedge clk);
   endtask
   task automatic ret_it(input logic [3:0] e);
      ret <= 1;
      @(posedge clk);
      ret <= 0;
      @(negedge clk);
      chk(insvc, e);
      @(posedge clk);
   endtask
   initial begin
      int fi[5] = '{3, 9, 10, 8, 5};
      logic [7:0] me[5] = '{8'ha0, 8'h80, 8'h80, 8'h80, 8'h90};
      logic [7:0] ee[5] = '{8'h00, 8'h02, 8'h04, 8'h01, 8'h00};
      logic [3:0] vn[5] = '{4'h5, 4'h9, 4'ha, 4'h8, 4'h4};
      repeat (16) @(posedge clk);
      rst <= 0;
      bus(0, 10'h2f4, 8'h00, q);
      chk(q, 0);
      bus(1, 10'h2f4, 8'hff, q);
      chk(q, 0);
      bus(0, 10'h2f4, 8'h00, q);
      chk(q, 32'h7);
      bus(0, 10'h3fc, 8'h00, q);
      chk(q, 32'h8000_0000);
      $display("test registers done");
      fl[0] <= 1;
      bus(1, 10'h2a0, 8'h02, q);
      offer(0, 0);
      bus(1, 10'h2a0, 8'h82, q);
      offer(1, 1);
      take_it(16'h000b);
      fl[0] <= 0;
      ret_it(4'h0);
      $display("test gate done");
      for (int k = 0; k < 5; k++) begin
         fl[fi[k]] <= 1;
         bus(1, 10'h2a0, me[k], q);
         bus(1, 10'h2f4, ee[k], q);
         offer(vn[k], 1);
         fl[fi[k]] <= 0;
         bus(1, 10'h2a0, 8'h00, q);
      end
      $display("test vectors done");
      fl[1:0] <= 2'b11;
      bus(1, 10'h2a0, 8'h8a, q);
      offer(1, 1);
      take_it(16'h000b);
      offer(0, 0);
      bus(1, 10'h2e0, 8'h08, q);
      offer(3, 1);
      take_it(16'h001b);
      @(negedge clk);
      chk(insvc, 4'h3);
      @(posedge clk);
      fl[1:0] <= 2'b00;
      ret_it(4'h1);
      ret_it(4'h0);
      $display("test nesting done");
      // Pin 0 in edge mode: a fall sets the flag, entering service clears it
      bus(1, 10'h300, 8'h01, q);
      bus(1, 10'h2a0, 8'h81, q);
      pin_n[0] <= 0;
      offer(0, 1);
      take_it(16'h0003);
      pin_n[0] <= 1;
      ret_it(4'h0);
      offer(0, 0);
      $display("test pins done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
